// ### hdl/sdcd_pkg.sv
// shared constants, command kinds and pin bundles for the command decoder
package sdcd_pkg;

   // ----------------------------------------------------------------
   // address field widths, set by density and data width
   // ----------------------------------------------------------------
   localparam int BA_W   = 3;
   localparam int ROW_W  = 14;
   localparam int COL_W  = 10;
   localparam int ADDR_W = 14;
   localparam int NUM_BANKS = 8;

   // ----------------------------------------------------------------
   // address bit positions with command meaning
   // ----------------------------------------------------------------
   localparam int AUTO_CLOSE_POS = 10;
   localparam int CHOP_SEL_POS   = 12;

   // ----------------------------------------------------------------
   // configuration words
   // ----------------------------------------------------------------
   localparam int NUM_CFG   = 4;
   localparam int CFG_SEL_W = 2;
   localparam int BL_LO     = 0;
   localparam int BL_W      = 2;
   localparam logic [BL_W-1:0]   BL_FIX8 = 2'h0;
   localparam logic [BL_W-1:0]   BL_OTF  = 2'h1;
   localparam logic [BL_W-1:0]   BL_FIX4 = 2'h2;
   localparam logic [ADDR_W-1:0] CFG_RST = 14'h0000;

   // ----------------------------------------------------------------
   // burst lengths in link clock periods (two beats each)
   // ----------------------------------------------------------------
   localparam logic [2:0] BURST8_CK = 3'h4;
   localparam logic [2:0] BURST4_CK = 3'h2;

   // ----------------------------------------------------------------
   // row, column, write strobe codes (high = 1)
   // ----------------------------------------------------------------
   localparam logic [2:0] RCW_CFG     = 3'h0;
   localparam logic [2:0] RCW_REFRESH = 3'h1;
   localparam logic [2:0] RCW_CLOSE   = 3'h2;
   localparam logic [2:0] RCW_OPEN    = 3'h3;
   localparam logic [2:0] RCW_WRITE   = 3'h4;
   localparam logic [2:0] RCW_READ    = 3'h5;
   localparam logic [2:0] RCW_CAL     = 3'h6;
   localparam logic [2:0] RCW_IDLE    = 3'h7;

   typedef enum logic [4:0] {
      K_NONE, K_DESEL, K_IDLE, K_CFG, K_REFRESH, K_SELF_ENTRY,
      K_SELF_EXIT, K_CLOSE_ONE, K_CLOSE_ALL, K_ROW_OPEN, K_WRITE,
      K_READ, K_CAL_START, K_CAL_RUN, K_CAL_SHORT, K_SLEEP_ENTRY,
      K_SLEEP_EXIT, K_ILLEGAL
   } sdcd_kind_t;

   typedef enum logic [1:0] {
      PWR_ACTIVE, PWR_SLEEP, PWR_SELF
   } sdcd_pwr_t;

   typedef struct packed {
      logic              cs_n;
      logic              ras_n;
      logic              cas_n;
      logic              we_n;
      logic              cke;
      logic [BA_W-1:0]   ba;
      logic [ADDR_W-1:0] addr;
   } sdcd_pins_t;

   typedef struct packed {
      logic              valid;
      sdcd_kind_t        kind;
      logic [BA_W-1:0]   ba;
      logic [ADDR_W-1:0] addr;
      logic              auto_close;
      logic              chop;
   } sdcd_cmd_t;

endpackage

// ### hdl/sdcd_sync.sv
// two-stage synchroniser for pins arriving from the controller
`timescale 1ns/1ps
module sdcd_sync #(
   parameter int W = 1
) (
   // clock
   input  wire logic         clk_sys,
   // pins
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clk_sys) begin
      meta <= d;
      q    <= meta;
   end
endmodule

// ### hdl/sdcd_cfg_words.sv
// four configuration words written by the load command
`timescale 1ns/1ps
module sdcd_cfg_words (
   // clock and reset
   input  wire logic                     clk_sys,
   input  wire logic                     rst,
   // write port
   input  wire logic                     load,
   input  wire logic [sdcd_pkg::CFG_SEL_W-1:0] sel,
   input  wire logic [sdcd_pkg::ADDR_W-1:0]    word,
   // stored words
   output logic [sdcd_pkg::NUM_CFG-1:0][sdcd_pkg::ADDR_W-1:0] words
);
   import sdcd_pkg::*;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         words <= {NUM_CFG{CFG_RST}};
      end else if (load) begin
         words[sel] <= word;
      end
   end
endmodule

// ### hdl/sdcd_decoder.sv
// command decoder and state tracker for the memory device
`timescale 1ns/1ps
// Notes on behaviour
// - command comes only from select, strobes and clock enable at clock rise, except self-renew exit
// - bank, row and column widths are set by density and data width
// - termination control level never changes decoding or state
// - bank commands other than close-all act only on the bank named with them
// - bank bits pick which of four config words takes the opcode
// - self-renew exit taken when clock enable rises, without clock edge
// - a started read or write burst always runs to its end
// - first config word decides fixed or per-command burst length
// - idle command starts nothing and lets work in progress finish
// - deselect behaves like idle: nothing starts, work continues
// - no refresh happens while in sleep
// - first long calibration is the startup one, later ones runtime
// - deselect blocks new commands, leaves ongoing work alone
// - a bank must be closed before another row opens in it
module sdcd_decoder (
   // system
   input  wire logic                  clk_sys,
   input  wire logic                  sys_rst,
   // controller pins
   input  wire logic                  ck,
   input  wire logic                  reset_n,
   input  wire logic                  termination_ctrl,
   input  wire sdcd_pkg::sdcd_pins_t  pins,
   // decoded command
   output sdcd_pkg::sdcd_cmd_t        cmd,
   output logic                       cmd_refused,
   output logic                       seq_error,
   // device state
   output sdcd_pkg::sdcd_pwr_t        power_state,
   output logic [sdcd_pkg::NUM_BANKS-1:0] bank_open,
   output logic                       burst_busy,
   output logic                       burst_write,
   output logic                       startup_cal_done,
   output logic [15:0]                refresh_count,
   output logic                       term_level,
   output logic [sdcd_pkg::NUM_CFG-1:0][sdcd_pkg::ADDR_W-1:0] cfg_words
);
   import sdcd_pkg::*;

   // ----------------------------------------------------------------
   // pin synchronisation
   // ----------------------------------------------------------------
   localparam int SYNC_W = 3 + $bits(sdcd_pins_t);

   logic [SYNC_W-1:0] sync_q;
   logic              ck_s;
   logic              reset_n_s;
   logic              term_s;
   sdcd_pins_t        p;

   // every pin is delayed alike, so a ck rise sees aligned bus levels
   sdcd_sync #(.W(SYNC_W)) u_sync (
      .clk_sys (clk_sys),
      .d       ({ck, reset_n, termination_ctrl, pins}),
      .q       (sync_q)
   );

   assign {ck_s, reset_n_s, term_s, p} = sync_q;

   wire rst = sys_rst | ~reset_n_s;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic              ck_q;
   logic              cke_q;
   logic              cke_lvl_q;
   logic [2:0]        burst_left;
   logic [BA_W-1:0]   burst_bank;
   logic              burst_ap;
   sdcd_pwr_t         next_pwr;
   sdcd_kind_t        next_kind;
   logic [NUM_BANKS-1:0] next_open;
   logic [2:0]        next_left;

   // ----------------------------------------------------------------
   // decoding
   // ----------------------------------------------------------------
   function automatic sdcd_kind_t base_kind(input logic [2:0] rcw,
                                            input logic       a10,
                                            input logic       cal_done);
      sdcd_kind_t k;
      k = K_ILLEGAL;
      case (rcw)
         RCW_CFG:     k = K_CFG;
         RCW_REFRESH: k = K_REFRESH;
         RCW_CLOSE:   k = a10 ? K_CLOSE_ALL : K_CLOSE_ONE;
         RCW_OPEN:    k = K_ROW_OPEN;
         RCW_WRITE:   k = K_WRITE;
         RCW_READ:    k = K_READ;
         RCW_CAL:     k = !a10 ? K_CAL_SHORT :
                          (cal_done ? K_CAL_RUN : K_CAL_START);
         RCW_IDLE:    k = K_IDLE;
         default:     k = K_ILLEGAL;
      endcase
      return k;
   endfunction

   wire [2:0] rcw      = {p.ras_n, p.cas_n, p.we_n};
   wire       ck_rise  = ck_s & ~ck_q;
   wire       keep     = cke_q & p.cke;
   wire       going_dn = cke_q & ~p.cke;
   wire       nop_like = p.cs_n | (rcw == RCW_IDLE);
   wire       a10      = p.addr[AUTO_CLOSE_POS];
   wire       a12      = p.addr[CHOP_SEL_POS];
   wire [BL_W-1:0] bl_mode = cfg_words[0][BL_LO +: BL_W];
   // fixed eight unless per-command select or fixed four is configured
   wire       chop     = (bl_mode == BL_OTF) ? ~a12 :
                         (bl_mode == BL_FIX4);
   wire sdcd_kind_t sel_kind = base_kind(rcw, a10, startup_cal_done);

   // termination level is deliberately absent from everything below except the term_level register
   always_comb begin
      next_kind = K_NONE;
      if (power_state == PWR_SELF) begin
         if (p.cke & ~cke_lvl_q) begin
            next_kind = K_SELF_EXIT;
         end
      end else if (ck_rise) begin
         if (power_state == PWR_SLEEP) begin
            if (p.cke) begin
               next_kind = K_SLEEP_EXIT;
            end
         end else if (keep) begin
            next_kind = p.cs_n ? K_DESEL : sel_kind;
         end else if (going_dn) begin
            if (!p.cs_n && rcw == RCW_REFRESH) begin
               next_kind = K_SELF_ENTRY;
            end else if (nop_like) begin
               next_kind = K_SLEEP_ENTRY;
            end else begin
               next_kind = K_ILLEGAL;
            end
         end
      end
   end

   wire is_rw    = (next_kind == K_READ) | (next_kind == K_WRITE);
   wire refuse   = is_rw & (burst_left != 3'h0);
   wire need_idl = (next_kind == K_CFG) | (next_kind == K_REFRESH) |
                   (next_kind == K_SELF_ENTRY);
   wire conflict = ((next_kind == K_ROW_OPEN) & bank_open[p.ba]) |
                   (need_idl & (|bank_open)) |
                   (next_kind == K_ILLEGAL);
   wire take     = (next_kind != K_NONE) & ~refuse & ~conflict;
   wire burst_end = ck_rise & (burst_left == 3'h1);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_pwr = power_state;
      case (take ? next_kind : K_NONE)
         K_SELF_ENTRY:  next_pwr = PWR_SELF;
         K_SLEEP_ENTRY: next_pwr = PWR_SLEEP;
         K_SELF_EXIT:   next_pwr = PWR_ACTIVE;
         K_SLEEP_EXIT:  next_pwr = PWR_ACTIVE;
         default:       next_pwr = power_state;
      endcase
   end

   always_comb begin
      next_open = bank_open;
      if (burst_end & burst_ap) begin
         next_open[burst_bank] = 1'b0;
      end
      if (take) begin
         case (next_kind)
            K_CLOSE_ONE: next_open[p.ba] = 1'b0;
            K_CLOSE_ALL: next_open = '0;
            K_ROW_OPEN:  next_open[p.ba] = 1'b1;
            default:     next_open = next_open;
         endcase
      end
   end

   // idle and deselect never load, so a running burst just counts down
   always_comb begin
      if (take & is_rw) begin
         next_left = chop ? BURST4_CK : BURST8_CK;
      end else if (ck_rise & (burst_left != 3'h0)) begin
         next_left = 3'(burst_left - 3'h1);
      end else begin
         next_left = burst_left;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ck_q       <= 1'b0;
         cke_q      <= 1'b0;
         cke_lvl_q  <= 1'b0;
         term_level <= 1'b0;
      end else begin
         ck_q       <= ck_s;
         cke_lvl_q  <= p.cke;
         term_level <= term_s;
         if (next_kind == K_SELF_EXIT) begin
            cke_q <= 1'b1;
         end else if (ck_rise) begin
            cke_q <= p.cke;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cmd         <= '0;
         cmd_refused <= 1'b0;
         seq_error   <= 1'b0;
      end else begin
         cmd.valid      <= next_kind != K_NONE;
         cmd.kind       <= next_kind;
         cmd.ba         <= p.ba;
         cmd.addr       <= p.addr;
         cmd.auto_close <= a10 & is_rw;
         cmd.chop       <= chop & is_rw;
         cmd_refused    <= refuse;
         seq_error      <= conflict;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         power_state      <= PWR_ACTIVE;
         bank_open        <= '0;
         burst_left       <= 3'h0;
         burst_busy       <= 1'b0;
         burst_bank       <= '0;
         burst_ap         <= 1'b0;
         burst_write      <= 1'b0;
         startup_cal_done <= 1'b0;
         refresh_count    <= 16'h0000;
      end else begin
         power_state <= next_pwr;
         bank_open   <= next_open;
         burst_left  <= next_left;
         burst_busy  <= next_left != 3'h0;
         if (take & is_rw) begin
            burst_bank  <= p.ba;
            burst_ap    <= a10;
            burst_write <= next_kind == K_WRITE;
         end
         if (take & (next_kind == K_CAL_START)) begin
            startup_cal_done <= 1'b1;
         end
         // sleep yields no refresh kind, so the count stands still
         if (take & (next_kind == K_REFRESH)) begin
            refresh_count <= 16'(refresh_count + 16'h0001);
         end
      end
   end

   // ----------------------------------------------------------------
   // configuration words
   // ----------------------------------------------------------------
   sdcd_cfg_words u_cfg (
      .clk_sys (clk_sys),
      .rst     (rst),
      .load    (take & (next_kind == K_CFG)),
      .sel     (p.ba[CFG_SEL_W-1:0]),
      .word    (p.addr),
      .words   (cfg_words)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_rw_taken;
      take && is_rw;
   endsequence

   sequence s_chop_taken;
      take && is_rw && chop;
   endsequence

   burst_load_a: assert property (
      s_rw_taken |=> burst_busy && burst_left == $past(next_left))
      else $error("burst not loaded on accepted access");

   chop_len_a: assert property (
      s_chop_taken |=> burst_left == BURST4_CK && cmd.chop)
      else $error("chopped burst has wrong length");

   burst_hold_a: assert property (
      burst_left != 3'h0 && !ck_rise |=> burst_left == $past(burst_left))
      else $error("burst length changed without clock rise");

   burst_step_a: assert property (
      burst_left != 3'h0 && ck_rise |=>
         burst_left == 3'($past(burst_left) - 3'h1))
      else $error("burst did not step on clock rise");

   busy_refuse_a: assert property (
      is_rw && burst_left != 3'h0 |=> cmd_refused &&
         burst_bank == $past(burst_bank) &&
         burst_write == $past(burst_write))
      else $error("access during burst was not refused");

   self_exit_a: assert property (
      power_state == PWR_SELF && p.cke && !cke_lvl_q && !ck_rise |=>
         power_state == PWR_ACTIVE && cmd.kind == K_SELF_EXIT)
      else $error("self-renew exit waited for clock edge");

   idle_keep_a: assert property (
      (next_kind == K_DESEL || next_kind == K_IDLE) && !burst_end |=>
         bank_open == $past(bank_open) &&
         power_state == $past(power_state))
      else $error("idle or deselect changed device state");

   bank_only_a: assert property (
      take && next_kind == K_CLOSE_ONE && !burst_end |=>
         ((bank_open | (8'h01 << $past(p.ba))) ==
            ($past(bank_open) | (8'h01 << $past(p.ba)))) &&
         !bank_open[$past(p.ba)])
      else $error("single close touched another bank");

   cfg_store_a: assert property (
      cmd.valid && cmd.kind == K_CFG && !seq_error |->
         cfg_words[cmd.ba[CFG_SEL_W-1:0]] == cmd.addr)
      else $error("config word not stored in selected slot");

   sleep_refresh_a: assert property (
      power_state == PWR_SLEEP |=> refresh_count == $past(refresh_count))
      else $error("refresh counted during sleep");

   startup_cal_a: assert property (
      cmd.valid && cmd.kind == K_CAL_START |-> !$past(startup_cal_done))
      else $error("startup calibration reported twice");

   open_conflict_a: assert property (
      next_kind == K_ROW_OPEN && bank_open[p.ba] |=> seq_error)
      else $error("row opened in bank already open");

endmodule

// ### verification/sdcd_ctrl_model.sv
// controller-side model driving the command bus and link clock
`timescale 1ns/1ps
module sdcd_ctrl_model
   import sdcd_pkg::*;
(
   // system
   input  wire logic           clk_sys,
   // link to device
   output logic                ck,
   output logic                reset_n,
   output sdcd_pkg::sdcd_pins_t pins
);
   // ----------------------------------------------------------------
   // idle bus
   // ----------------------------------------------------------------
   initial begin
      ck      = 1'b0;
      reset_n = 1'b1;
      pins    = 22'h3E_0000;
   end

   // ----------------------------------------------------------------
   // bus cycles
   // ----------------------------------------------------------------
   // ck stands still between commands; pins settle 3 clk_sys before rise
   task automatic issue(input logic cs, input logic [2:0] rcw,
                        input logic [2:0] ba, input logic [13:0] addr,
                        input logic cke);
      pins = {cs, rcw, cke, ba, addr};
      repeat (3) @(negedge clk_sys);
      ck = 1'b1;
      repeat (4) @(negedge clk_sys);
      ck = 1'b0;
      // released bus: deselected, cke kept, other lines inverted so none look held
      pins = {1'b1, ~rcw, cke, ~ba, ~addr};
   endtask

   // clock enable moves with ck still, as a self-renew exit needs
   task automatic set_cke(input logic v);
      pins.cke = v;
   endtask

   task automatic pulse_reset;
      reset_n = 1'b0;
      repeat (4) @(negedge clk_sys);
      reset_n = 1'b1;
   endtask
endmodule

// ### verification/tb_sdcd_decoder.sv
// self-checking bench for the command decoder
`timescale 1ns/1ps
module tb_sdcd_decoder;
   import sdcd_pkg::*;
   typedef struct packed {
      logic cs; logic [2:0] rcw; logic [2:0] ba; logic [13:0] addr;
      sdcd_kind_t kind; logic chop; logic rf; logic se; logic [7:0] bo;
   } sdcd_row_t;

   logic                clk_sys;
   logic                sys_rst;
   logic                termination_ctrl;
   logic                ck;
   logic                reset_n;
   sdcd_pins_t          pins;
   sdcd_cmd_t           cmd;
   logic                cmd_refused;
   logic                seq_error;
   sdcd_pwr_t           power_state;
   logic [7:0]          bank_open;
   logic                burst_busy;
   logic                burst_write;
   logic                startup_cal_done;
   logic [15:0]         refresh_count;
   logic                term_level;
   logic [NUM_CFG-1:0][ADDR_W-1:0] cfg_words;
   sdcd_kind_t          got_kind;
   logic                got_chop;
   logic                got_rf;
   logic                got_se;
   int                  errors;
   int                  comparisons;

   sdcd_ctrl_model ctl (.clk_sys(clk_sys), .ck(ck), .reset_n(reset_n),
                        .pins(pins));
   sdcd_decoder uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .ck(ck),
      .reset_n(reset_n), .termination_ctrl(termination_ctrl), .pins(pins),
      .cmd(cmd), .cmd_refused(cmd_refused), .seq_error(seq_error),
      .power_state(power_state), .bank_open(bank_open),
      .burst_busy(burst_busy), .burst_write(burst_write),
      .startup_cal_done(startup_cal_done), .refresh_count(refresh_count),
      .term_level(term_level), .cfg_words(cfg_words));

   // ----------------------------------------------------------------
   // clock, monitor and checks
   // ----------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // pulses stand one cycle, so they are caught here
   always @(posedge clk_sys) begin
      if (cmd.valid === 1'b1) begin
         got_kind <= cmd.kind;
         got_chop <= cmd.chop;
      end
      if (cmd_refused === 1'b1) got_rf <= 1'b1;
      if (seq_error === 1'b1) got_se <= 1'b1;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic go(input logic cs, input logic [2:0] rcw,
                     input logic [2:0] ba, input logic [13:0] addr,
                     input logic cke);
      got_kind = K_NONE;
      got_chop = 1'b0;
      got_rf = 1'b0;
      got_se = 1'b0;
      termination_ctrl = ~termination_ctrl;
      ctl.issue(cs, rcw, ba, addr, cke);
      // one more cycle keeps the link clock period at 160 ns
      @(negedge clk_sys);
   endtask

   task automatic results;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // ordinary cases, in order: each row leaves the state for the next
   // ----------------------------------------------------------------
   sdcd_row_t rows [36] = '{
      '{0, RCW_IDLE, 0, 14'h0000, K_IDLE, 0, 0, 0, 8'h00},
      '{1, RCW_IDLE, 0, 14'h0000, K_DESEL, 0, 0, 0, 8'h00},
      '{0, RCW_CFG, 2, 14'h1234, K_CFG, 0, 0, 0, 8'h00},
      '{0, RCW_CFG, 0, 14'h0001, K_CFG, 0, 0, 0, 8'h00},
      '{0, RCW_REFRESH, 0, 14'h0000, K_REFRESH, 0, 0, 0, 8'h00},
      '{0, RCW_CAL, 0, 14'h0400, K_CAL_START, 0, 0, 0, 8'h00},
      '{0, RCW_CAL, 0, 14'h0400, K_CAL_RUN, 0, 0, 0, 8'h00},
      '{0, RCW_CAL, 0, 14'h0000, K_CAL_SHORT, 0, 0, 0, 8'h00},
      '{0, RCW_OPEN, 3, 14'h0055, K_ROW_OPEN, 0, 0, 0, 8'h08},
      '{0, RCW_OPEN, 3, 14'h00AA, K_NONE, 0, 0, 1, 8'h08},
      '{0, RCW_REFRESH, 0, 14'h0000, K_NONE, 0, 0, 1, 8'h08},
      '{0, RCW_OPEN, 5, 14'h0011, K_ROW_OPEN, 0, 0, 0, 8'h28},
      '{0, RCW_CLOSE, 3, 14'h0000, K_CLOSE_ONE, 0, 0, 0, 8'h20},
      '{0, RCW_READ, 5, 14'h0000, K_READ, 1, 0, 0, 8'h20},
      '{0, RCW_IDLE, 0, 14'h0000, K_IDLE, 0, 0, 0, 8'h20},
      '{0, RCW_IDLE, 0, 14'h0000, K_IDLE, 0, 0, 0, 8'h20},
      '{0, RCW_WRITE, 5, 14'h1400, K_WRITE, 0, 0, 0, 8'h20},
      '{0, RCW_READ, 5, 14'h0000, K_NONE, 0, 1, 0, 8'h20},
      '{1, RCW_IDLE, 0, 14'h0000, K_DESEL, 0, 0, 0, 8'h20},
      '{0, RCW_IDLE, 0, 14'h0000, K_IDLE, 0, 0, 0, 8'h20},
      '{0, RCW_IDLE, 0, 14'h0000, K_IDLE, 0, 0, 0, 8'h00},
      '{0, RCW_OPEN, 1, 14'h0007, K_ROW_OPEN, 0, 0, 0, 8'h02},
      '{0, RCW_CLOSE, 0, 14'h0400, K_CLOSE_ALL, 0, 0, 0, 8'h00},
      '{0, RCW_CFG, 0, 14'h0000, K_CFG, 0, 0, 0, 8'h00},
      '{0, RCW_OPEN, 4, 14'h0009, K_ROW_OPEN, 0, 0, 0, 8'h10},
      '{0, RCW_READ, 4, 14'h0400, K_READ, 0, 0, 0, 8'h10},
      '{0, RCW_IDLE, 0, 14'h0000, K_IDLE, 0, 0, 0, 8'h10},
      '{0, RCW_IDLE, 0, 14'h0000, K_IDLE, 0, 0, 0, 8'h10},
      '{0, RCW_IDLE, 0, 14'h0000, K_IDLE, 0, 0, 0, 8'h10},
      '{0, RCW_IDLE, 0, 14'h0000, K_IDLE, 0, 0, 0, 8'h00},
      '{0, RCW_CFG, 0, 14'h0002, K_CFG, 0, 0, 0, 8'h00},
      '{0, RCW_OPEN, 6, 14'h0003, K_ROW_OPEN, 0, 0, 0, 8'h40},
      '{0, RCW_READ, 6, 14'h1000, K_READ, 1, 0, 0, 8'h40},
      '{0, RCW_IDLE, 0, 14'h0000, K_IDLE, 0, 0, 0, 8'h40},
      '{0, RCW_IDLE, 0, 14'h0000, K_IDLE, 0, 0, 0, 8'h40},
      '{0, RCW_CLOSE, 0, 14'h0400, K_CLOSE_ALL, 0, 0, 0, 8'h00}};

   initial begin
      #100_000;
      errors++;
      results();
   end

   initial begin
      errors = 0;
      comparisons = 0;
      sys_rst = 1'b1;
      termination_ctrl = 1'b0;
      repeat (20) @(negedge clk_sys);
      sys_rst = 1'b0;
      @(negedge clk_sys);
      chk(32'(power_state), 32'(PWR_ACTIVE));
      chk(32'(bank_open), 32'h0000_0000);
      chk(32'(cfg_words[0]), 32'(CFG_RST));
      // first rise only records clock enable
      go(1'b0, RCW_IDLE, 3'h0, 14'h0000, 1'b1);
      foreach (rows[i]) begin
         go(rows[i].cs, rows[i].rcw, rows[i].ba, rows[i].addr, 1'b1);
         if (rows[i].kind != K_NONE)
            chk(32'(got_kind), 32'(rows[i].kind));
         if (rows[i].kind inside {K_READ, K_WRITE})
            chk(32'(got_chop), 32'(rows[i].chop));
         chk(32'(got_rf), 32'(rows[i].rf));
         chk(32'(got_se), 32'(rows[i].se));
         chk(32'(bank_open), 32'(rows[i].bo));
         chk(32'(term_level), 32'(termination_ctrl));
      end
      chk(32'(cfg_words[2]), 32'h0000_1234);
      chk(32'(cfg_words[0]), 32'h0000_0002);
      chk(32'(refresh_count), 32'h0000_0001);
      chk(32'(startup_cal_done), 32'h0000_0001);

      // sleep: refresh pins while asleep must not count
      go(1'b0, RCW_IDLE, 3'h0, 14'h0000, 1'b0);
      chk(32'(power_state), 32'(PWR_SLEEP));
      go(1'b0, RCW_REFRESH, 3'h0, 14'h0000, 1'b0);
      chk(32'(refresh_count), 32'h0000_0001);
      go(1'b0, RCW_IDLE, 3'h0, 14'h0000, 1'b1);
      chk(32'(power_state), 32'(PWR_ACTIVE));

      // self-renew: exit with the link clock standing still
      go(1'b0, RCW_REFRESH, 3'h0, 14'h0000, 1'b0);
      chk(32'(power_state), 32'(PWR_SELF));
      got_kind = K_NONE;
      ctl.set_cke(1'b1);
      repeat (6) @(negedge clk_sys);
      chk(32'(power_state), 32'(PWR_ACTIVE));
      chk(32'(got_kind), 32'(K_SELF_EXIT));

      // device reset pin
      ctl.pulse_reset();
      repeat (4) @(negedge clk_sys);
      chk(32'(cfg_words[2]), 32'(CFG_RST));
      chk(32'(refresh_count), 32'h0000_0000);
      chk(32'(startup_cal_done), 32'h0000_0000);
      results();
   end
endmodule
